// ### scb_map.svh
// register map, field positions, reset values and timing counts of the config bank
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

`define SCB_ADDR_FAULT 7'h5f
`define SCB_ADDR_NVM_CTL 7'h6a
`define SCB_ADDR_PORT_SET 7'h6b
`define SCB_ADDR_SELF_TEST 7'h6d
`define SCB_ADDR_PERSIST 7'h70
`define SCB_ADDR_OFF_X 7'h71
`define SCB_ADDR_OFF_Y 7'h72
`define SCB_ADDR_OFF_Z 7'h73
`define SCB_ADDR_CMD 7'h7e

`define SCB_FAULT_LONG_BIT 1
`define SCB_FAULT_FATAL_BIT 2
`define SCB_PROG_EN_BIT 1
`define SCB_THREE_WIRE_BIT 0
`define SCB_AUX_MAG_BIT 4
`define SCB_ST_EN_BIT 0
`define SCB_ST_SIGN_BIT 2
`define SCB_ST_AMP_BIT 3
`define SCB_SERIAL_EN_BIT 0
`define SCB_WDT_LONG_BIT 1
`define SCB_WDT_EN_BIT 2
`define SCB_OFF_EN_BIT 3

`define SCB_RESET_BYTE 8'h00
`define SCB_CMD_NVM_PROG 8'ha0

`define SCB_SYS_CLK_HZ 20000000
`define SCB_WDT_SHORT_US 1250
`define SCB_WDT_LONG_US 40000
`define SCB_WDT_SHORT_CYC (`SCB_WDT_SHORT_US * (`SCB_SYS_CLK_HZ / 1000000))
`define SCB_WDT_LONG_CYC (`SCB_WDT_LONG_US * (`SCB_SYS_CLK_HZ / 1000000))

`endif

// ### scb_pkg.sv
// types shared by the serial port and the register bank
package scb_pkg;
    typedef enum logic [1:0] {
        SCB_IDLE = 2'b00,
        SCB_CMD = 2'b01,
        SCB_DATA = 2'b10
    } scb_spi_st_e;

    typedef logic [11:0] scb_sample_t;

    typedef struct packed {
        logic [1:0] csb_s;
        logic [1:0] sck_s;
        logic [1:0] sdi_s;
        logic sck_prev;
        scb_spi_st_e st;
        logic [2:0] bit_cnt;
        logic [7:0] in_sr;
        logic [7:0] out_sr;
        logic [6:0] addr;
        logic rnw;
        logic load;
        logic wr_stb;
        logic [7:0] wdata;
        logic sdo;
        logic sdo_oe;
        logic sdx_oe;
    } scb_spi_s;

    typedef struct packed {
        logic err_long;
        logic err_fatal;
        logic halt;
        logic prog_en;
        logic three_wire;
        logic aux_mag;
        logic st_en;
        logic st_pos;
        logic st_high;
        logic [3:0] persist;
        logic two_wire;
        logic [2:0][7:0] off;
        logic [2:0][11:0] comp;
        logic nvm_store;
        logic [19:0] wdt_cnt;
        logic wdt_to;
    } scb_bank_s;
endpackage

// ### scb_bus_if.sv
// byte access path between the serial port and the register bank
`timescale 1ns/1ps
interface scb_bus_if;
    logic wr_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic sdi_lvl;
    logic three_wire;
    modport port (output wr_stb, addr, wdata, sdi_lvl, input rdata, three_wire);
    modport bank (input wr_stb, addr, wdata, sdi_lvl, output rdata, three_wire);
endinterface

// ### scb_spi_port.sv
// serial slave: synchronises the pins and turns frames into byte accesses
`timescale 1ns/1ps
module scb_spi_port (
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic csb_n, // chip select pin, low active
    input wire logic sck, // serial clock pin
    input wire logic sdi_pin_i, // data input pin level
    output logic sdi_pin_o, // data pin drive in three wire mode
    output logic sdi_pin_oe, // data pin enable, three wire read
    output logic sdo_o, // data out pin
    output logic sdo_oe, // data out enable, four wire read
    scb_bus_if.port bus // byte access path
);
    import scb_pkg::*;

    scb_spi_s q, d;
    logic cs_act;
    logic rise;
    logic fall;

    // edges found on the second sync stage only
    assign cs_act = !q.csb_s[1];
    assign rise = q.sck_s[1] & !q.sck_prev;
    assign fall = !q.sck_s[1] & q.sck_prev;

    // frame: bit7 read flag, 7 bit address, then data bytes with address increment
    always_comb begin
        d = q;
        d.wr_stb = 1'b0;
        d.load = 1'b0;
        d.csb_s = {q.csb_s[0], csb_n};
        d.sck_s = {q.sck_s[0], sck};
        d.sdi_s = {q.sdi_s[0], sdi_pin_i};
        d.sck_prev = q.sck_s[1];
        if (!cs_act) begin
            d.st = SCB_IDLE;
            d.bit_cnt = 3'h0;
            d.sdo_oe = 1'b0;
            d.sdx_oe = 1'b0;
        end else begin
            case (q.st)
                SCB_IDLE: begin
                    d.st = SCB_CMD;
                    d.bit_cnt = 3'h0;
                end
                SCB_CMD: begin
                    if (rise) begin
                        d.in_sr = {q.in_sr[6:0], q.sdi_s[1]};
                        d.bit_cnt = q.bit_cnt + 3'h1;
                        if (q.bit_cnt == 3'h7) begin
                            d.rnw = q.in_sr[6];
                            d.addr = {q.in_sr[5:0], q.sdi_s[1]};
                            d.load = q.in_sr[6];
                            d.st = SCB_DATA;
                        end
                    end
                end
                SCB_DATA: begin
                    // write address steps only once the strobe has used it
                    if (q.wr_stb) begin
                        d.addr = q.addr + 7'h01;
                    end
                    // read data fetched a cycle after the address settles
                    if (q.load) begin
                        d.out_sr = bus.rdata;
                    end
                    if (rise) begin
                        d.in_sr = {q.in_sr[6:0], q.sdi_s[1]};
                        d.bit_cnt = q.bit_cnt + 3'h1;
                        if (q.bit_cnt == 3'h7) begin
                            d.wr_stb = !q.rnw;
                            d.wdata = {q.in_sr[6:0], q.sdi_s[1]};
                            d.load = q.rnw;
                            if (q.rnw) begin
                                d.addr = q.addr + 7'h01;
                            end
                        end
                    end
                    // drive on falling edge so the host samples on rising
                    if (fall && q.rnw) begin
                        d.sdo = q.out_sr[7];
                        d.out_sr = {q.out_sr[6:0], 1'b0};
                        d.sdo_oe = !bus.three_wire;
                        d.sdx_oe = bus.three_wire;
                    end
                end
                default: begin
                    d.st = SCB_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.csb_s <= 2'h3;
            q.sck_s <= 2'h3; // idle high, so no false edge after reset
            q.sck_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.wr_stb = q.wr_stb;
    assign bus.addr = q.addr;
    assign bus.wdata = q.wdata;
    assign bus.sdi_lvl = q.sdi_s[1];
    assign sdo_o = q.sdo;
    assign sdo_oe = q.sdo_oe;
    assign sdi_pin_o = q.sdo;
    assign sdi_pin_oe = q.sdx_oe;

    // only one of the two data pins may be driven
    chk_one_driver: assert property (@(posedge sys_clk) disable iff (rst)
        !(q.sdo_oe && q.sdx_oe)) else $error("both data pins driven");
    chk_wire_mode: assert property (@(posedge sys_clk) disable iff (rst)
        q.sdx_oe |-> $past(bus.three_wire)) else $error("three wire pin driven in four wire");
endmodule

// ### scb_reg_bank.sv
// configuration and status register bank with offset compensation and watchdog
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_reg_bank #(
    parameter int WDT_SHORT_CYC = `SCB_WDT_SHORT_CYC, // short watchdog count
    parameter int WDT_LONG_CYC = `SCB_WDT_LONG_CYC // long watchdog count
) (
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic csb_n, // chip select pin, low active
    input wire logic sck, // serial clock pin
    input wire logic sdi_pin_i, // data input pin level
    output logic sdi_pin_o, // data pin drive, three wire read
    output logic sdi_pin_oe, // data pin enable
    output logic sdo_o, // data out pin
    output logic sdo_oe, // data out enable
    input wire logic long_proc_err, // pulse: processing overran
    input wire logic fatal_err, // pulse: fatal internal error
    input wire scb_pkg::scb_sample_t acc_x, // raw x sample
    input wire scb_pkg::scb_sample_t acc_y, // raw y sample
    input wire scb_pkg::scb_sample_t acc_z, // raw z sample
    output scb_pkg::scb_sample_t comp_x, // compensated x
    output scb_pkg::scb_sample_t comp_y, // compensated y
    output scb_pkg::scb_sample_t comp_z, // compensated z
    output logic proc_halt, // processing halted
    output logic prog_erase_en, // memory may be programmed
    output logic three_wire_select, // primary port in three wire
    output logic aux_mag_en, // auxiliary port runs magnetometer
    output logic self_test_en, // self-test on
    output logic self_test_pos, // positive excitation
    output logic self_test_high, // high amplitude
    output logic two_wire_en, // two-wire bus enabled
    output logic wdt_timeout, // pulse: data pin watchdog fired
    output logic nvm_store, // pulse: store backed registers
    output logic [31:0] nvm_image // backed registers to store
);
    import scb_pkg::*;

    scb_bus_if bus ();
    scb_bank_s q, d;
    scb_sample_t raw [3];
    scb_sample_t sum [3];
    logic [19:0] wdt_limit;

    scb_spi_port u_port (
        .sys_clk(sys_clk),
        .rst(rst),
        .csb_n(csb_n),
        .sck(sck),
        .sdi_pin_i(sdi_pin_i),
        .sdi_pin_o(sdi_pin_o),
        .sdi_pin_oe(sdi_pin_oe),
        .sdo_o(sdo_o),
        .sdo_oe(sdo_oe),
        .bus(bus.port)
    );

    // byte address decode, shared by read and write paths
    function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
        return a == r;
    endfunction

    // offset is signed; result wraps in twelve bits
    assign raw[0] = acc_x;
    assign raw[1] = acc_y;
    assign raw[2] = acc_z;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            assign sum[g] = raw[g] + {{4{q.off[g][7]}}, q.off[g]};
        end
    endgenerate

    // watchdog period from the persistent select bit
    assign wdt_limit = q.persist[`SCB_WDT_LONG_BIT] ? 20'(WDT_LONG_CYC) :
        20'(WDT_SHORT_CYC);

    // read mux; reserved bits and unmapped addresses return zero
    always_comb begin
        bus.rdata = `SCB_RESET_BYTE;
        if (hit(bus.addr, `SCB_ADDR_FAULT)) begin
            bus.rdata[`SCB_FAULT_LONG_BIT] = q.err_long;
            bus.rdata[`SCB_FAULT_FATAL_BIT] = q.err_fatal;
        end else if (hit(bus.addr, `SCB_ADDR_NVM_CTL)) begin
            bus.rdata[`SCB_PROG_EN_BIT] = q.prog_en;
        end else if (hit(bus.addr, `SCB_ADDR_PORT_SET)) begin
            bus.rdata[`SCB_THREE_WIRE_BIT] = q.three_wire;
            bus.rdata[`SCB_AUX_MAG_BIT] = q.aux_mag;
        end else if (hit(bus.addr, `SCB_ADDR_SELF_TEST)) begin
            bus.rdata[`SCB_ST_EN_BIT] = q.st_en;
            bus.rdata[`SCB_ST_SIGN_BIT] = q.st_pos;
            bus.rdata[`SCB_ST_AMP_BIT] = q.st_high;
        end else if (hit(bus.addr, `SCB_ADDR_PERSIST)) begin
            bus.rdata[3:0] = q.persist;
        end else if (hit(bus.addr, `SCB_ADDR_OFF_X)) begin
            bus.rdata = q.off[0];
        end else if (hit(bus.addr, `SCB_ADDR_OFF_Y)) begin
            bus.rdata = q.off[1];
        end else if (hit(bus.addr, `SCB_ADDR_OFF_Z)) begin
            bus.rdata = q.off[2];
        end
    end
    assign bus.three_wire = q.three_wire;

    // next state: error capture, register writes, compensation, watchdog
    always_comb begin
        d = q;
        d.nvm_store = 1'b0;
        d.wdt_to = 1'b0;
        // error flags are sticky until reset and stop processing
        d.err_long = q.err_long | long_proc_err;
        d.err_fatal = q.err_fatal | fatal_err;
        d.halt = q.halt | long_proc_err | fatal_err;
        if (bus.wr_stb) begin
            if (hit(bus.addr, `SCB_ADDR_NVM_CTL)) begin
                d.prog_en = bus.wdata[`SCB_PROG_EN_BIT];
            end
            if (hit(bus.addr, `SCB_ADDR_PORT_SET)) begin
                d.three_wire = bus.wdata[`SCB_THREE_WIRE_BIT];
                d.aux_mag = bus.wdata[`SCB_AUX_MAG_BIT];
            end
            if (hit(bus.addr, `SCB_ADDR_SELF_TEST)) begin
                d.st_en = bus.wdata[`SCB_ST_EN_BIT];
                d.st_pos = bus.wdata[`SCB_ST_SIGN_BIT];
                d.st_high = bus.wdata[`SCB_ST_AMP_BIT];
            end
            if (hit(bus.addr, `SCB_ADDR_PERSIST)) begin
                d.persist = bus.wdata[3:0];
            end
            if (hit(bus.addr, `SCB_ADDR_OFF_X)) begin
                d.off[0] = bus.wdata;
            end
            if (hit(bus.addr, `SCB_ADDR_OFF_Y)) begin
                d.off[1] = bus.wdata;
            end
            if (hit(bus.addr, `SCB_ADDR_OFF_Z)) begin
                d.off[2] = bus.wdata;
            end
            // store only while programming is permitted
            if (hit(bus.addr, `SCB_ADDR_CMD) && bus.wdata == `SCB_CMD_NVM_PROG) begin
                d.nvm_store = q.prog_en;
            end
        end
        // registered so the enable output carries no logic after the flop
        d.two_wire = !d.persist[`SCB_SERIAL_EN_BIT];
        // a halted core keeps the last compensated samples
        if (!q.halt) begin
            for (int i = 0; i < 3; i++) begin
                d.comp[i] = q.persist[`SCB_OFF_EN_BIT] ? sum[i] : raw[i];
            end
        end
        // watchdog: data pin held low in two-wire mode for the full period
        if (!q.persist[`SCB_SERIAL_EN_BIT] && q.persist[`SCB_WDT_EN_BIT]
                && !bus.sdi_lvl) begin
            if (q.wdt_cnt >= wdt_limit - 20'h00001) begin
                d.wdt_cnt = 20'h00000;
                d.wdt_to = 1'b1;
            end else begin
                d.wdt_cnt = q.wdt_cnt + 20'h00001;
            end
        end else begin
            d.wdt_cnt = 20'h00000;
        end
    end

    // state register, every control bit zero after reset except two_wire, which resets to one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.two_wire <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign comp_x = q.comp[0];
    assign comp_y = q.comp[1];
    assign comp_z = q.comp[2];
    assign proc_halt = q.halt;
    assign prog_erase_en = q.prog_en;
    assign three_wire_select = q.three_wire;
    assign aux_mag_en = q.aux_mag;
    assign self_test_en = q.st_en;
    assign self_test_pos = q.st_pos;
    assign self_test_high = q.st_high;
    assign two_wire_en = q.two_wire;
    assign wdt_timeout = q.wdt_to;
    assign nvm_store = q.nvm_store;
    assign nvm_image = {4'h0, q.persist, q.off[0], q.off[1], q.off[2]};

    chk_long_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        long_proc_err |=> q.err_long && q.halt) else $error("long fault not held");
    chk_fatal_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        q.err_fatal |=> q.err_fatal && q.halt) else $error("fatal fault lost");
    chk_store_gated: assert property (@(posedge sys_clk) disable iff (rst)
        q.nvm_store |-> $past(q.prog_en)) else $error("store without program enable");
    chk_store_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        bus.wr_stb && bus.addr == `SCB_ADDR_CMD && bus.wdata == `SCB_CMD_NVM_PROG
        && q.prog_en |=> nvm_store ##1 !nvm_store) else $error("store pulse wrong");
    chk_port_write: assert property (@(posedge sys_clk) disable iff (rst)
        bus.wr_stb && bus.addr == `SCB_ADDR_PORT_SET |=> three_wire_select ==
        $past(bus.wdata[0]) && aux_mag_en == $past(bus.wdata[4])) else $error("port bits");
    chk_offset_off: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && !q.persist[3] && !q.halt |=> comp_x == $past(acc_x))
        else $error("offset added");
    chk_offset_on: assert property (@(posedge sys_clk) disable iff (rst)
        q.persist[3] && !q.halt |=> comp_y == 12'($past(acc_y) +
        {{4{$past(q.off[1][7])}}, $past(q.off[1])})) else $error("offset missing");
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        bus.addr == `SCB_ADDR_SELF_TEST |-> (bus.rdata & 8'hf2) == 8'h00)
        else $error("reserved bit set");
    chk_wdt_period: assert property (@(posedge sys_clk) disable iff (rst)
        q.wdt_to |-> $past(q.wdt_cnt) == wdt_limit - 20'h00001) else $error("watchdog period");
    chk_wdt_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !q.persist[2] |=> q.wdt_cnt == 20'h00000) else $error("watchdog ran disabled");
endmodule

// ### scb_host_model.sv
// host processor model: drives frames on the serial port of the config bank
`timescale 1ns/1ps
module scb_host_model (
    output logic csb_n, // chip select, low active
    output logic sck, // serial clock, idles high between frames
    output logic sdi_drv, // host level on the data pin
    input wire logic sdi_wire, // resolved data pin level
    input wire logic sdo, // data out pin
    input wire logic sdo_oe, // data out enable
    input wire logic three_wire // reads come back on the data pin
);
    localparam time HALF = 200; // half of the 400 ns link clock

    initial begin
        csb_n = 1'b1;
        sck = 1'b1;
        sdi_drv = 1'b1;
    end

    // level of the data pin between frames, used for the watchdog runs
    task automatic set_pin(input logic v);
        sdi_drv <= v;
    endtask

    // one byte access: command byte then one data byte, msb first, mode 3
    task automatic xfer(input logic rnw, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rnw, addr, wdata};
        rdata = 8'h00;
        #13; // keeps the link edges off the system clock edges
        csb_n <= 1'b0;
        #(HALF);
        for (int i = 15; i >= 0; i--) begin
            sck <= 1'b0;
            // a released pin shows no stale level: the model flips its last bit
            if (rnw && i < 8) begin
                sdi_drv <= ~sdi_drv;
            end else begin
                sdi_drv <= frame[i];
            end
            #(HALF);
            sck <= 1'b1;
            // sample mid-way through the high phase to allow for the port's pin sync
            #(HALF / 2);
            if (rnw && i < 8) begin
                rdata[i] = three_wire ? sdi_wire : (sdo_oe ? sdo : 1'bx);
            end
            #(HALF / 2);
        end
        csb_n <= 1'b1;
        #(2 * HALF);
    endtask
endmodule

// ### scb_reg_bank_tb_top.sv
// self-checking bench of the config register bank driven through the host model
`timescale 1ns/1ps
module scb_reg_bank_tb_top;
    import scb_pkg::*;
    localparam int SHORT_CYC = 20; // shortened watchdog counts
    localparam int LONG_CYC = 50;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic csb_n, sck, sdi_drv, sdi_wire, sdi_pin_o, sdi_pin_oe, sdo_o, sdo_oe;
    logic long_proc_err = 1'b0;
    logic fatal_err = 1'b0;
    logic tw_mode = 1'b0;
    scb_sample_t acc_x = 12'h000;
    scb_sample_t acc_y = 12'h000;
    scb_sample_t acc_z = 12'h000;
    scb_sample_t comp_x, comp_y, comp_z;
    logic proc_halt, prog_erase_en, three_wire_select, aux_mag_en;
    logic self_test_en, self_test_pos, self_test_high, two_wire_en, wdt_timeout, nvm_store;
    logic [31:0] nvm_image;
    logic [31:0] img_seen = 32'h0;
    int err_total = 0;
    int checked = 0;
    int store_cnt = 0;
    int wdt_cnt = 0;
    logic [7:0] rd;

    always #25 sys_clk = ~sys_clk;

    // data pin: the port drives it in three wire reads, otherwise the host
    assign sdi_wire = sdi_pin_oe ? sdi_pin_o : sdi_drv;

    scb_reg_bank #(.WDT_SHORT_CYC(SHORT_CYC), .WDT_LONG_CYC(LONG_CYC)) uut (
        .sys_clk(sys_clk), .rst(rst), .csb_n(csb_n), .sck(sck), .sdi_pin_i(sdi_wire),
        .sdi_pin_o(sdi_pin_o), .sdi_pin_oe(sdi_pin_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .long_proc_err(long_proc_err), .fatal_err(fatal_err),
        .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
        .comp_x(comp_x), .comp_y(comp_y), .comp_z(comp_z), .proc_halt(proc_halt),
        .prog_erase_en(prog_erase_en), .three_wire_select(three_wire_select),
        .aux_mag_en(aux_mag_en), .self_test_en(self_test_en), .self_test_pos(self_test_pos),
        .self_test_high(self_test_high), .two_wire_en(two_wire_en),
        .wdt_timeout(wdt_timeout), .nvm_store(nvm_store), .nvm_image(nvm_image));

    scb_host_model host (.csb_n(csb_n), .sck(sck), .sdi_drv(sdi_drv), .sdi_wire(sdi_wire),
        .sdo(sdo_o), .sdo_oe(sdo_oe), .three_wire(tw_mode));

    // one-cycle pulses are counted where they stand
    always @(posedge sys_clk) begin
        if (nvm_store === 1'b1) begin
            store_cnt <= store_cnt + 1;
            img_seen <= nvm_image;
        end
        if (wdt_timeout === 1'b1) begin
            wdt_cnt <= wdt_cnt + 1;
        end
    end

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        host.xfer(1'b0, a, d, dummy);
    endtask

    task automatic rdr(input logic [6:0] a, output logic [7:0] d);
        host.xfer(1'b1, a, 8'h00, d);
    endtask

    // every register, the command and an unmapped place read zero out of reset
    task automatic t_reset_values();
        logic [6:0] a [10] = '{7'h5f, 7'h6a, 7'h6b, 7'h6d, 7'h70, 7'h71, 7'h72, 7'h73, 7'h7e,
            7'h60};
        foreach (a[i]) begin
            rdr(a[i], rd);
            check("reset value", rd, 8'h00);
        end
        check("idle outputs", {proc_halt, prog_erase_en, three_wire_select, aux_mag_en,
            self_test_en, self_test_pos, self_test_high, nvm_store}, 8'h00);
        check("two-wire on", two_wire_en, 1'b1);
    endtask

    // all ones written, only the documented bits stick; read-only stays clear
    task automatic t_fields();
        logic [6:0] a [5] = '{7'h6a, 7'h6d, 7'h70, 7'h5f, 7'h7e};
        logic [7:0] e [5] = '{8'h02, 8'h0d, 8'h0f, 8'h00, 8'h00};
        logic [7:0] v [3] = '{8'h01, 8'h04, 8'h08};
        foreach (a[i]) begin
            wr(a[i], 8'hff);
            rdr(a[i], rd);
            check("masked readback", rd, e[i]);
        end
        check("program enable", prog_erase_en, 1'b1);
        check("two-wire off", two_wire_en, 1'b0);
        check("wrong code stores", store_cnt, 0);
        foreach (v[i]) begin
            wr(7'h6d, v[i]);
            check("self-test bits", {self_test_en, self_test_pos, self_test_high},
                {v[i][0], v[i][2], v[i][3]});
        end
        wr(7'h70, 8'h00);
        wr(7'h6a, 8'h00);
        check("program disable", prog_erase_en, 1'b0);
    endtask

    // offsets are added, sign-extended, only while the enable bit is set
    task automatic t_offsets();
        wr(7'h71, 8'h05);
        wr(7'h72, 8'hfe);
        wr(7'h73, 8'h80);
        @(posedge sys_clk);
        acc_x <= 12'h100;
        acc_y <= 12'h002;
        acc_z <= 12'hfff;
        repeat (3) @(posedge sys_clk);
        check("raw passes x", comp_x, 12'h100);
        wr(7'h70, 8'h08);
        repeat (3) @(posedge sys_clk);
        check("comp x", comp_x, 12'h105);
        check("comp y", comp_y, 12'h000);
        check("comp z", comp_z, 12'hf7f);
        rdr(7'h71, rd);
        check("x offset", rd, 8'h05);
        rdr(7'h72, rd);
        check("y offset", rd, 8'hfe);
        rdr(7'h73, rd);
        check("z offset", rd, 8'h80);
    endtask

    // the program command stores the backed image only while enabled
    task automatic t_store();
        wr(7'h70, 8'h0a);
        wr(7'h7e, 8'ha0);
        repeat (5) @(posedge sys_clk);
        check("store while locked", store_cnt, 0);
        wr(7'h6a, 8'h02);
        wr(7'h7e, 8'ha0);
        repeat (5) @(posedge sys_clk);
        check("store count", store_cnt, 1);
        check("store image", img_seen, {8'h0a, 8'h05, 8'hfe, 8'h80});
        rdr(7'h7e, rd);
        check("command reads zero", rd, 8'h00);
    endtask

    // holds the data pin low and times the watchdog pulse
    task automatic wdt_run(input logic [7:0] cfg, input int limit, input bit fire);
        int w0;
        int k;
        wr(7'h70, cfg);
        host.set_pin(1'b1);
        repeat (5) @(posedge sys_clk);
        w0 = wdt_cnt;
        host.set_pin(1'b0);
        k = 0;
        while (wdt_cnt == w0 && k < limit + 20) begin
            @(posedge sys_clk);
            k++;
        end
        if (fire) begin
            check("watchdog delay", (k >= limit && k <= limit + 6), 1'b1);
        end else begin
            check("watchdog silent", wdt_cnt, w0);
        end
        host.set_pin(1'b1);
    endtask

    task automatic t_wdt();
        wdt_run(8'h04, SHORT_CYC, 1'b1);
        wdt_run(8'h06, LONG_CYC, 1'b1);
        wdt_run(8'h00, LONG_CYC, 1'b0);
        wdt_run(8'h05, LONG_CYC, 1'b0);
    endtask

    // three wire mode answers on the data pin; auxiliary mode follows bit 4
    task automatic t_three_wire();
        wr(7'h6b, 8'hff);
        check("three wire and aux", {three_wire_select, aux_mag_en}, 2'b11);
        tw_mode = 1'b1;
        rdr(7'h6b, rd);
        check("port settings", rd, 8'h11);
        rdr(7'h71, rd);
        check("x offset 3-wire", rd, 8'h05);
        wr(7'h6b, 8'h10);
        tw_mode = 1'b0;
        check("four wire", {three_wire_select, aux_mag_en}, 2'b01);
        rdr(7'h6b, rd);
        check("port settings", rd, 8'h10);
    endtask

    task automatic pulse_err(input bit fatal);
        @(posedge sys_clk);
        long_proc_err <= !fatal;
        fatal_err <= fatal;
        @(posedge sys_clk);
        long_proc_err <= 1'b0;
        fatal_err <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // faults are sticky, read-only and freeze processing until reset
    task automatic t_faults();
        wr(7'h70, 8'h00);
        acc_x <= 12'h123;
        pulse_err(1'b0);
        check("halted", proc_halt, 1'b1);
        acc_x <= 12'h456;
        repeat (3) @(posedge sys_clk);
        check("frozen", comp_x, 12'h123);
        rdr(7'h5f, rd);
        check("long flag", rd, 8'h02);
        pulse_err(1'b1);
        wr(7'h5f, 8'h00);
        rdr(7'h5f, rd);
        check("both flags", rd, 8'h06);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("halt cleared", proc_halt, 1'b0);
        rdr(7'h5f, rd);
        check("flags cleared", rd, 8'h00);
        rdr(7'h71, rd);
        check("x offset reset", rd, 8'h00);
    endtask

    // a hang is cut short well past the expected run length
    initial begin
        #2ms;
        err_total++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_reset_values();
        t_fields();
        t_offsets();
        t_store();
        t_wdt();
        t_three_wire();
        t_faults();
        finish_test();
    end
endmodule
